// File: rtl/aspw_top.sv
// Two-axis status word two and BCD current position words
// Overview of operation
// RULE1 - Bit 0 mirrors origin sensor input
// RULE2 - Bit 1 mirrors emergency stop input
// RULE3 - Bit 2 mirrors external interrupt input
// RULE4 - Bit 3 mirrors counter-clockwise limit switch
// RULE5 - Bit 4 mirrors clockwise limit switch
// RULE6 - Bits 5,6 mirror general outputs
// RULE7 - Bit 7 set when stopped at zero
// RULE8 - Bit 8 decel zone near destination
// RULE9 - Bit 9 accel zone after start
// RULE10 - Bit 10 following error within zone
// RULE11 - Bit 11 decelerating from decel point
// RULE12 - Bit 12 constant speed after acceleration
// RULE13 - Bit 13 accelerating from start command
// RULE14 - Bits 14,15 show active direction
// RULE15 - Position held as eight BCD digits
// RULE16 - Position zero until origin established
// RULE17 - X words 4-6, Y 11-13
// RULE18 - Position sign in first status word
// RULE19 - Host only reads these words
`timescale 1ns/1ps
`default_nettype none

module aspw_top #(
    parameter int ZONE_W = 8                           // Width of zone settings
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   sys_error,     // System error strobe/level
    input  wire aspw_pkg::aspw_axis_in_t x_in,
    input  wire aspw_pkg::aspw_axis_in_t y_in,
    input  wire logic [4:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    output logic                        irq
);

    // ********************************************
    // Helper functions
    // ********************************************

    // Add or subtract one on an eight-digit BCD magnitude
    function automatic logic [31:0] bcd_step(input logic [31:0] v, input logic up);
        logic [31:0] r;
        logic        carry;
        r     = v;
        carry = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            // A digit wraps and carries on 9 going up, 0 going down
            if (carry)
            begin
                carry       = (v[i*4 +: 4] == (up ? 4'h9 : 4'h0));
                r[i*4 +: 4] = carry ? (up ? 4'h0 : 4'h9) : (up ? v[i*4 +: 4] + 4'h1 : v[i*4 +: 4] - 4'h1);
            end
        end
        return r;
    endfunction : bcd_step

    // ********************************************
    // Per-axis state
    // ********************************************
    typedef struct packed {
        logic [15:0] status;                           // Status word two
        logic [31:0] pos;                              // BCD magnitude
        logic        neg;                              // Sign of position
        logic        origin_set;                       // Origin has been established
        logic [7:0]  travel;                           // Steps since start, saturating
    } aspw_axis_st_t;

    aspw_axis_st_t ax_q [2];                           // Index 0 = X, 1 = Y
    aspw_axis_st_t ax_d [2];
    aspw_pkg::aspw_axis_in_t ain [2];
    logic [ZONE_W-1:0] decel_zone_q [2];               // Decel zone width per axis
    logic [ZONE_W-1:0] accel_zone_q [2];               // Accel zone width per axis
    logic [ZONE_W-1:0] decel_zone_d [2];
    logic [ZONE_W-1:0] accel_zone_d [2];
    logic [3:0]        irq_stat_q, irq_stat_d;         // Sticky events
    logic [3:0]        irq_en_q,   irq_en_d;           // Event enables
    logic [15:0]       rdata_d;
    logic              irq_d;

    assign ain[0] = x_in;
    assign ain[1] = y_in;

    // ********************************************
    // Axis next-state logic
    // ********************************************

    // Inputs and flags recomputed every cycle from the motion core
    always_comb
    begin
        for (int a = 0; a < 2; a++)
        begin
            logic [15:0] s;
            logic        stopped;
            s       = ax_q[a].status;
            stopped = ~ain[a].moving;
            ax_d[a] = ax_q[a];
            // Input mirrors ignore system error on purpose
            s[aspw_pkg::BIT_ORIGIN_IN] = ain[a].origin_sensor; // RULE1
            s[aspw_pkg::BIT_ESTOP_IN]  = ain[a].estop_open; // RULE2
            s[aspw_pkg::BIT_EXT_INT]   = ain[a].ext_interrupt; // RULE3
            s[aspw_pkg::BIT_CCW_LS]    = ain[a].ccw_limit_switch_input; // RULE4
            s[aspw_pkg::BIT_CW_LS]     = ain[a].cw_limit_switch_input; // RULE5
            s[aspw_pkg::BIT_OUT_ONE]   = ain[a].general_output_one; // RULE6
            s[aspw_pkg::BIT_OUT_TWO]   = ain[a].general_output_two; // RULE6
            s[aspw_pkg::BIT_IN_POS]    = ain[a].error_in_zone & ~ain[a].pulses_to_counter; // RULE10
            // Position tracks steps only once origin exists
            if (ain[a].set_current_position_cmd)
            begin
                ax_d[a].pos        = ain[a].new_position_bcd;            // RULE16
                // A loaded zero is never reported negative
                ax_d[a].neg        = ain[a].new_position_neg
                                     && (ain[a].new_position_bcd != aspw_pkg::RST_POSITION); // RULE18
                ax_d[a].origin_set = 1'b1;
            end
            else if (ain[a].origin_search_done)
            begin
                ax_d[a].pos        = aspw_pkg::RST_POSITION;             // RULE16
                ax_d[a].neg        = 1'b0;
                ax_d[a].origin_set = 1'b1;
            end
            else if (ax_q[a].origin_set && ain[a].step_valid)
            begin
                // Sign-magnitude: moving away from zero grows magnitude
                if (ax_q[a].pos == aspw_pkg::RST_POSITION)
                begin
                    ax_d[a].pos = bcd_step(ax_q[a].pos, 1'b1);           // RULE15
                    ax_d[a].neg = ain[a].step_ccw;
                end
                else
                begin
                    ax_d[a].pos = bcd_step(ax_q[a].pos, ain[a].step_ccw == ax_q[a].neg);
                end
            end
            // Travel since start drives the accel zone
            if (ain[a].start_positioning_cmd || ain[a].jog_cmd)
                ax_d[a].travel = 8'h00;
            else if (ain[a].step_valid && ax_q[a].travel != 8'hFF)
                ax_d[a].travel = ax_q[a].travel + 8'h01;
            // Accel zone
            if (ain[a].start_positioning_cmd || ain[a].jog_cmd)
                s[aspw_pkg::BIT_ACCEL_ZONE] = 1'b1; // RULE9
            else if (ain[a].decel_stop_done || (ax_q[a].travel >= 8'(accel_zone_q[a])))
                s[aspw_pkg::BIT_ACCEL_ZONE] = 1'b0; // RULE9
            // Decel zone
            if (ain[a].positioning_done || ain[a].estop_done)
                s[aspw_pkg::BIT_DECEL_ZONE] = 1'b0; // RULE8
            else if (ain[a].moving && ain[a].remaining < 8'(decel_zone_q[a]))
                s[aspw_pkg::BIT_DECEL_ZONE] = 1'b1; // RULE8
            // Speed profile: accel, constant, decel
            if (ain[a].start_positioning_cmd || ain[a].jog_cmd)
            begin
                s[aspw_pkg::BIT_ACCEL]     = 1'b1; // RULE13
                s[aspw_pkg::BIT_CONST_SPD] = 1'b0; // RULE12
            end
            else if (ain[a].decel_point)
            begin
                s[aspw_pkg::BIT_DECEL]     = 1'b1; // RULE11
                s[aspw_pkg::BIT_ACCEL]     = 1'b0; // RULE13
                s[aspw_pkg::BIT_CONST_SPD] = 1'b0;
            end
            else if (s[aspw_pkg::BIT_ACCEL] && !s[aspw_pkg::BIT_ACCEL_ZONE])
            begin
                s[aspw_pkg::BIT_ACCEL]     = 1'b0; // RULE13
                s[aspw_pkg::BIT_CONST_SPD] = 1'b1; // RULE12
            end
            if (ain[a].positioning_done || ain[a].decel_stop_done)
                s[aspw_pkg::BIT_DECEL] = 1'b0; // RULE11
            // Direction follows the last step; stopping clears both
            if (ain[a].step_valid)
            begin
                s[aspw_pkg::BIT_CCW_MOVE] = ain[a].step_ccw; // RULE14
                s[aspw_pkg::BIT_CW_MOVE]  = ~ain[a].step_ccw; // RULE14
            end
            if (stopped)
            begin
                s[aspw_pkg::BIT_CCW_MOVE] = 1'b0;
                s[aspw_pkg::BIT_CW_MOVE]  = 1'b0;
            end
            // At origin: stopped, defined and zero
            s[aspw_pkg::BIT_AT_ORIGIN] = stopped & ax_d[a].origin_set
                                         & (ax_d[a].pos == aspw_pkg::RST_POSITION); // RULE7
            // System error clears motion flags, position, sign and origin only
            if (sys_error)
            begin
                s[aspw_pkg::BIT_AT_ORIGIN]  = 1'b0; // RULE7
                s[aspw_pkg::BIT_DECEL_ZONE] = 1'b0; // RULE8
                s[aspw_pkg::BIT_ACCEL_ZONE] = 1'b0; // RULE9
                s[aspw_pkg::BIT_DECEL]      = 1'b0; // RULE11
                s[aspw_pkg::BIT_CONST_SPD]  = 1'b0; // RULE12
                s[aspw_pkg::BIT_ACCEL]      = 1'b0; // RULE13
                s[aspw_pkg::BIT_CCW_MOVE]   = 1'b0; // RULE14
                s[aspw_pkg::BIT_CW_MOVE]    = 1'b0; // RULE14
                ax_d[a].pos        = aspw_pkg::RST_POSITION; // RULE16
                ax_d[a].neg        = 1'b0;
                ax_d[a].origin_set = 1'b0;
            end
            ax_d[a].status = s;
        end
    end

    // Axis state registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int a = 0; a < 2; a++)
            begin
                ax_q[a] <= '0;
            end
        end
        else
        begin
            ax_q <= ax_d;
        end
    end

    // ********************************************
    // Register bus, zones and interrupts
    // ********************************************

    // Read mux; status words are read only, writes there are dropped
    always_comb
    begin
        rdata_d = aspw_pkg::RST_WORD;
        case (reg_addr)
            aspw_pkg::OFF_X_STATUS_ONE: rdata_d = {15'h0000, ax_q[0].neg};   // RULE18
            aspw_pkg::OFF_Y_STATUS_ONE: rdata_d = {15'h0000, ax_q[1].neg};   // RULE18
            aspw_pkg::OFF_X_STATUS_TWO: rdata_d = ax_q[0].status;            // RULE17
            aspw_pkg::OFF_X_POS_UPPER:  rdata_d = ax_q[0].pos[31:16];        // RULE15
            aspw_pkg::OFF_X_POS_LOWER:  rdata_d = ax_q[0].pos[15:0];         // RULE15
            aspw_pkg::OFF_Y_STATUS_TWO: rdata_d = ax_q[1].status;            // RULE17
            aspw_pkg::OFF_Y_POS_UPPER:  rdata_d = ax_q[1].pos[31:16];
            aspw_pkg::OFF_Y_POS_LOWER:  rdata_d = ax_q[1].pos[15:0];
            aspw_pkg::OFF_IRQ_STATUS:   rdata_d = {12'h000, irq_stat_q};
            aspw_pkg::OFF_IRQ_ENABLE:   rdata_d = {12'h000, irq_en_q};
            aspw_pkg::OFF_ZONE_X:       rdata_d = {8'(decel_zone_q[0]), 8'(accel_zone_q[0])};
            aspw_pkg::OFF_ZONE_Y:       rdata_d = {8'(decel_zone_q[1]), 8'(accel_zone_q[1])};
            default:                    rdata_d = aspw_pkg::RST_WORD;
        endcase
        if (!reg_rd)
            rdata_d = aspw_pkg::RST_WORD;
    end

    // Config and interrupt next values; a new event beats a clear
    always_comb
    begin
        logic [3:0] ev;
        ev = {ax_q[1].status[aspw_pkg::BIT_DECEL] & ~ax_d[1].status[aspw_pkg::BIT_DECEL],
              ~ax_q[1].status[aspw_pkg::BIT_AT_ORIGIN] & ax_d[1].status[aspw_pkg::BIT_AT_ORIGIN],
              ax_q[0].status[aspw_pkg::BIT_DECEL] & ~ax_d[0].status[aspw_pkg::BIT_DECEL],
              ~ax_q[0].status[aspw_pkg::BIT_AT_ORIGIN] & ax_d[0].status[aspw_pkg::BIT_AT_ORIGIN]};
        decel_zone_d = decel_zone_q;
        accel_zone_d = accel_zone_q;
        irq_en_d     = irq_en_q;
        irq_stat_d   = irq_stat_q;
        if (reg_wr)
        begin
            case (reg_addr)
                aspw_pkg::OFF_IRQ_CLEAR:  irq_stat_d = irq_stat_q & ~reg_wdata[3:0];
                aspw_pkg::OFF_IRQ_ENABLE: irq_en_d   = reg_wdata[3:0];
                aspw_pkg::OFF_ZONE_X:
                begin
                    decel_zone_d[0] = ZONE_W'(reg_wdata[15:8]);
                    accel_zone_d[0] = ZONE_W'(reg_wdata[7:0]);
                end
                aspw_pkg::OFF_ZONE_Y:
                begin
                    decel_zone_d[1] = ZONE_W'(reg_wdata[15:8]);
                    accel_zone_d[1] = ZONE_W'(reg_wdata[7:0]);
                end
                default: ;
            endcase
        end
        irq_stat_d = irq_stat_d | ev;
        irq_d      = |(irq_stat_d & irq_en_d);
    end

    // Bus, config and interrupt registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata    <= aspw_pkg::RST_WORD;
            irq          <= 1'b0;
            irq_stat_q   <= aspw_pkg::RST_IRQ;
            irq_en_q     <= aspw_pkg::RST_IRQ;
            decel_zone_q <= '{default: ZONE_W'(aspw_pkg::RST_ZONE)};
            accel_zone_q <= '{default: ZONE_W'(aspw_pkg::RST_ZONE)};
        end
        else
        begin
            reg_rdata    <= rdata_d;
            irq          <= irq_d;
            irq_stat_q   <= irq_stat_d;
            irq_en_q     <= irq_en_d;
            decel_zone_q <= decel_zone_d;
            accel_zone_q <= accel_zone_d;
        end
    end

endmodule : aspw_top

`default_nettype wire

// File: rtl/aspw_pkg.sv
// Package for the per-axis status and position word block
package aspw_pkg;

    // ********************************************
    // Register word offsets (index of 16-bit word)
    // ********************************************
    localparam logic [4:0] OFF_X_STATUS_TWO = 5'h04;   // X status two
    localparam logic [4:0] OFF_X_POS_UPPER  = 5'h05;   // X upper digits
    localparam logic [4:0] OFF_X_POS_LOWER  = 5'h06;   // X lower digits
    localparam logic [4:0] OFF_Y_STATUS_TWO = 5'h0B;   // Y status two
    localparam logic [4:0] OFF_Y_POS_UPPER  = 5'h0C;   // Y upper digits
    localparam logic [4:0] OFF_Y_POS_LOWER  = 5'h0D;   // Y lower digits
    localparam logic [4:0] OFF_X_STATUS_ONE = 5'h03;   // X sign word
    localparam logic [4:0] OFF_Y_STATUS_ONE = 5'h0A;   // Y sign word
    localparam logic [4:0] OFF_IRQ_STATUS   = 5'h10;   // Sticky events, RO
    localparam logic [4:0] OFF_IRQ_CLEAR    = 5'h11;   // W1C
    localparam logic [4:0] OFF_IRQ_ENABLE   = 5'h12;   // Enables, RW
    localparam logic [4:0] OFF_ZONE_X       = 5'h13;   // X zones: decel hi, accel lo
    localparam logic [4:0] OFF_ZONE_Y       = 5'h14;   // Y zones

    // ********************************************
    // Status word two bit positions
    // ********************************************
    localparam int BIT_ORIGIN_IN  = 0;
    localparam int BIT_ESTOP_IN   = 1;
    localparam int BIT_EXT_INT    = 2;
    localparam int BIT_CCW_LS     = 3;
    localparam int BIT_CW_LS      = 4;
    localparam int BIT_OUT_ONE    = 5;
    localparam int BIT_OUT_TWO    = 6;
    localparam int BIT_AT_ORIGIN  = 7;
    localparam int BIT_DECEL_ZONE = 8;
    localparam int BIT_ACCEL_ZONE = 9;
    localparam int BIT_IN_POS     = 10;
    localparam int BIT_DECEL      = 11;
    localparam int BIT_CONST_SPD  = 12;
    localparam int BIT_ACCEL      = 13;
    localparam int BIT_CCW_MOVE   = 14;
    localparam int BIT_CW_MOVE    = 15;
    localparam int BIT_POS_SIGN   = 0;                 // Sign bit in first status word

    // ********************************************
    // Reset values
    // ********************************************
    localparam logic [15:0] RST_WORD     = 16'h0000;   // Words and flags after reset
    localparam logic [31:0] RST_POSITION = 32'h0000_0000;
    localparam logic [7:0]  RST_ZONE     = 8'h10;      // Default zone width, in steps
    localparam logic [3:0]  RST_IRQ      = 4'h0;

    // Interrupt event bits
    localparam int IRQ_X_ORIGIN = 0;                   // X reached position zero
    localparam int IRQ_X_STOP   = 1;                   // X motion ended
    localparam int IRQ_Y_ORIGIN = 2;
    localparam int IRQ_Y_STOP   = 3;

    // Per-axis inputs from the motion core and the pins
    typedef struct packed {
        logic        origin_sensor;        // Origin level
        logic        estop_open;           // E-stop active
        logic        ext_interrupt;        // Interrupt level
        logic        ccw_limit_switch_input;
        logic        cw_limit_switch_input;
        logic        general_output_one;
        logic        general_output_two;
        logic        start_positioning_cmd; // Strobes
        logic        jog_cmd;
        logic        decel_stop_done;      // Done strobes
        logic        estop_done;
        logic        positioning_done;
        logic        origin_search_done;
        logic        set_current_position_cmd;
        logic [31:0] new_position_bcd;     // Loaded by set
        logic        new_position_neg;
        logic        step_valid;           // One pulse out
        logic        step_ccw;             // Its direction
        logic [7:0]  remaining;            // Steps to go
        logic        decel_point;          // Decel start
        logic        error_in_zone;        // Error in zone
        logic        pulses_to_counter;    // Counter fed
        logic        moving;               // In motion
    } aspw_axis_in_t;

endpackage : aspw_pkg

// File: tb/aspw_assertions.sv
// Checker for the axis status and position words
`timescale 1ns/1ps
`default_nettype none
module aspw_assertions #(
    parameter int ZONE_W = 8                          // Zone setting width
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    sys_error,
    input wire aspw_pkg::aspw_axis_in_t x_in,
    input wire aspw_pkg::aspw_axis_in_t y_in,
    input wire logic [4:0]              reg_addr,
    input wire logic [15:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [15:0]             reg_rdata,
    input wire logic                    irq
);
    // ****************
    // Input history
    // ****************
    aspw_pkg::aspw_axis_in_t x_q1, x_q2, y_q1, y_q2;  // A read shows inputs of two edges back
    logic [1:0]              age_q;                    // Edges since reset, saturating
    logic                    settled;                  // Status past its reset value
    assign settled = (age_q == 2'h3);
    // History shift, no reset needed
    always_ff @(posedge mclk)
    begin
        x_q1 <= x_in;
        x_q2 <= x_q1;
        y_q1 <= y_in;
        y_q2 <= y_q1;
    end
    // Age restarts at each reset so stale status is not judged
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************
    // Properties
    // ****************
    sequence s_rd_xs; reg_rd && reg_addr == aspw_pkg::OFF_X_STATUS_TWO && settled; endsequence
    sequence s_rd_ys; reg_rd && reg_addr == aspw_pkg::OFF_Y_STATUS_TWO && settled; endsequence
    sequence s_err2; sys_error [*2]; endsequence
    property p_x_origin; s_rd_xs |=> reg_rdata[0] == x_q2.origin_sensor; endproperty
    a_x_origin: assert property (p_x_origin) else $error("bit 0 wrong");
    property p_x_estop; s_rd_xs |=> reg_rdata[1] == x_q2.estop_open; endproperty
    a_x_estop: assert property (p_x_estop) else $error("bit 1 wrong");
    property p_x_ext; s_rd_xs |=> reg_rdata[2] == x_q2.ext_interrupt; endproperty
    a_x_ext: assert property (p_x_ext) else $error("bit 2 wrong");
    property p_y_ccw; s_rd_ys |=> reg_rdata[3] == y_q2.ccw_limit_switch_input; endproperty
    a_y_ccw: assert property (p_y_ccw) else $error("bit 3 wrong");
    property p_y_cw; s_rd_ys |=> reg_rdata[4] == y_q2.cw_limit_switch_input; endproperty
    a_y_cw: assert property (p_y_cw) else $error("bit 4 wrong");
    property p_x_outs; s_rd_xs |=> reg_rdata[6:5] == {x_q2.general_output_two, x_q2.general_output_one}; endproperty
    a_x_outs: assert property (p_x_outs) else $error("bits 6:5 wrong");
    property p_y_inpos; s_rd_ys |=> reg_rdata[10] == (y_q2.error_in_zone && !y_q2.pulses_to_counter); endproperty
    a_y_inpos: assert property (p_y_inpos) else $error("bit 10 wrong");
    property p_err_motion; s_err2 ##0 s_rd_xs |=> (reg_rdata & 16'hFB80) == 16'h0000; endproperty
    a_err_motion: assert property (p_err_motion) else $error("flags kept");
    property p_err_pos; s_err2 ##0 (reg_rd && reg_addr == aspw_pkg::OFF_Y_POS_LOWER) |=> reg_rdata == 16'h0000; endproperty
    a_err_pos: assert property (p_err_pos) else $error("position kept");
    property p_err_sign; s_err2 ##0 (reg_rd && reg_addr == aspw_pkg::OFF_X_STATUS_ONE) |=> !reg_rdata[0]; endproperty
    a_err_sign: assert property (p_err_sign) else $error("sign kept");
    property p_unmapped; reg_rd && reg_addr == 5'h1F |=> reg_rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
endmodule : aspw_assertions
bind aspw_top aspw_assertions #(.ZONE_W(ZONE_W)) u_aspw_chk (.*);
`default_nettype wire

// File: tb/aspw_host.sv
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module aspw_host (
    input  wire logic        mclk,
    output logic [4:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    // Idle bus at time zero
    initial
    begin
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; released lines show inverses
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // Status words are only ever read
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
endmodule : aspw_host
`default_nettype wire

// File: tb/axis_status_position_words_test.sv
// Self-checking bench for the axis status and position words
`timescale 1ns/1ps
`default_nettype none
module axis_status_position_words_test;
    logic                    mclk = 1'b0;       // 200 MHz clock
    logic                    rst = 1'b1;        // Async reset, high
    logic                    sys_error = 1'b0;  // System error level
    aspw_pkg::aspw_axis_in_t x_in = '0;         // X axis inputs
    aspw_pkg::aspw_axis_in_t y_in = '0;         // Y axis inputs
    logic [4:0]              reg_addr;
    logic [15:0]             reg_wdata, reg_rdata, v;
    logic                    reg_wr, reg_rd, irq;
    int                      fails = 0;
    int                      n_compared = 0;
    always #2.5 mclk = ~mclk;
    aspw_top uut (.mclk(mclk), .rst(rst), .sys_error(sys_error), .x_in(x_in), .y_in(y_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    aspw_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // ****************
    // Compare and helper routines
    // ****************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t irq %b expected %b", $time, got, exp);
        end
    endtask : chk1
    // Masked read compare
    task automatic rdchk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        host.rd(a, v);
        chk16(v & m, e);
    endtask : rdchk
    // Mirror bits and in-position bit as the status word must show them
    function automatic logic [15:0] mirror(input aspw_pkg::aspw_axis_in_t a);
        mirror = {5'h00, a.error_in_zone & ~a.pulses_to_counter, 3'h0, a.general_output_two, a.general_output_one,
            a.cw_limit_switch_input, a.ccw_limit_switch_input, a.ext_interrupt, a.estop_open, a.origin_sensor};
    endfunction : mirror
    // Random levels with every strobe and motion held off
    function automatic aspw_pkg::aspw_axis_in_t quiet(input logic [63:0] r);
        quiet = aspw_pkg::aspw_axis_in_t'(r[60:0]);
        {quiet.start_positioning_cmd, quiet.jog_cmd, quiet.decel_stop_done, quiet.estop_done} = 4'h0;
        {quiet.positioning_done, quiet.origin_search_done, quiet.set_current_position_cmd} = 3'h0;
        {quiet.step_valid, quiet.decel_point, quiet.moving} = 3'h0;
    endfunction : quiet
    function automatic logic [31:0] rand_bcd();
        for (int i = 0; i < 8; i++)
            rand_bcd[i*4 +: 4] = 4'($urandom % 10);
    endfunction : rand_bcd
    task automatic conclude();
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // Watchdog, far beyond the fewer than two hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge mclk);
        fails++;
        conclude();
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        logic [31:0] p;
        p = $urandom(32'h31B9);
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        host.wr(aspw_pkg::OFF_IRQ_ENABLE, 16'h0001);
        rdchk(aspw_pkg::OFF_X_POS_UPPER, 16'hFFFF, 16'h0000);
        rdchk(5'h1F, 16'hFFFF, 16'h0000);
        // Random levels; pass 0 X all ones, pass 1 Y all zeros
        for (int i = 0; i < 16; i++)
        begin
            x_in <= quiet(i == 0 ? ~64'h0 : {$urandom, $urandom});
            y_in <= quiet(i == 1 ? 64'h0 : {$urandom, $urandom});
            sys_error <= 1'($urandom);
            repeat (3) @(posedge mclk);
            rdchk(aspw_pkg::OFF_X_STATUS_TWO, 16'h047F, mirror(x_in));
            rdchk(aspw_pkg::OFF_Y_STATUS_TWO, 16'h047F, mirror(y_in));
        end
        sys_error <= 1'b0;
        x_in <= '0;
        @(posedge mclk);
        x_in.origin_search_done <= 1'b1;
        @(posedge mclk);
        x_in.origin_search_done <= 1'b0;
        repeat (3) @(posedge mclk);
        rdchk(aspw_pkg::OFF_X_STATUS_TWO, 16'h0080, 16'h0080);
        chk1(irq, 1'b1);
        host.wr(aspw_pkg::OFF_IRQ_ENABLE, 16'h0000);
        repeat (2) @(posedge mclk);
        chk1(irq, 1'b0);
        // Load a random BCD position with negative sign
        p = rand_bcd();
        x_in.new_position_bcd <= p;
        x_in.new_position_neg <= 1'b1;
        x_in.set_current_position_cmd <= 1'b1;
        @(posedge mclk);
        x_in.set_current_position_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
        rdchk(aspw_pkg::OFF_X_POS_UPPER, 16'hFFFF, p[31:16]);
        rdchk(aspw_pkg::OFF_X_POS_LOWER, 16'hFFFF, p[15:0]);
        rdchk(aspw_pkg::OFF_X_STATUS_ONE, 16'h0001, {15'h0000, p != 32'h0});
        host.wr(aspw_pkg::OFF_IRQ_CLEAR, 16'h0001);
        rdchk(aspw_pkg::OFF_IRQ_STATUS, 16'h0001, 16'h0000);
        // Start, one CCW step, near the destination
        x_in.moving <= 1'b1;
        x_in.remaining <= 8'h05;
        x_in.start_positioning_cmd <= 1'b1;
        @(posedge mclk);
        x_in.start_positioning_cmd <= 1'b0;
        x_in.step_valid <= 1'b1;
        x_in.step_ccw <= 1'b1;
        @(posedge mclk);
        x_in.step_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        rdchk(aspw_pkg::OFF_X_STATUS_TWO, 16'hE380, 16'h6300);
        x_in.decel_point <= 1'b1;
        @(posedge mclk);
        x_in.decel_point <= 1'b0;
        repeat (2) @(posedge mclk);
        rdchk(aspw_pkg::OFF_X_STATUS_TWO, 16'h2800, 16'h0800);
        // Held system error clears motion, position and sign
        sys_error <= 1'b1;
        repeat (2) @(posedge mclk);
        rdchk(aspw_pkg::OFF_X_STATUS_TWO, 16'hFB80, 16'h0000);
        rdchk(aspw_pkg::OFF_X_POS_UPPER, 16'hFFFF, 16'h0000);
        rdchk(aspw_pkg::OFF_Y_POS_LOWER, 16'hFFFF, 16'h0000);
        rdchk(aspw_pkg::OFF_X_STATUS_ONE, 16'h0001, 16'h0000);
        conclude();
    end
endmodule : axis_status_position_words_test
`default_nettype wire
